// ==== logic/scp_top.sv ====
// system clock, reset and power control: clock source and divider,
// sleep modes, peripheral gating, resets, interrupts, ldo and adc rate
// assumes oscillator pins and event pins are asynchronous to clk,
// and that clk is much faster than any oscillator it samples
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_top #(
  parameter int NPER = 8,
  parameter int LOW_DIV = 400,
  parameter logic [1:0] ADC_FASTEST = 2'h0,
  parameter logic [15:0] FLASH_KB = 16'h0080,
  parameter logic [15:0] SRAM_KB = 16'h0020,
  parameter logic [31:0] PERIPH_PRESENT = 32'h000000ff,
  parameter logic [31:0] PIN_PRESENT = 32'h0000ffff
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [3:0] osc_pins,
  input wire logic [`SCP_NUM_EV-1:0] event_pins,
  output logic sys_tick,
  output logic cpu_clk_en,
  output logic [NPER-1:0] periph_clk_en,
  output logic [NPER-1:0] periph_rst,
  output logic pwm_tick,
  output logic multiplier_in_use,
  output logic [1:0] pll_ref_sel,
  output logic [4:0] crystal_freq_code,
  output logic main_osc_en,
  output logic internal_osc_en,
  output logic [3:0] ldo_code,
  output logic [1:0] adc_rate_select,
  output logic sys_irq,
  output logic chip_reset
);
  // software-visible state
  logic [16:0] clk_cfg_reg; // requested clock configuration
  logic [3:0] pwm_cfg_reg; // bit0 divide on, [3:1] power of two
  logic gating_reg; // automatic gating in sleep states
  logic [NPER-1:0] run_en_reg, slp_en_reg, dslp_en_reg;
  logic [`SCP_NUM_IRQ-1:0] raw_irq_reg, irq_mask_reg;
  logic [`SCP_NUM_RC-1:0] rst_cause_reg;
  logic [1:0] rst_cfg_reg; // brownout / ldo-low reset enables
  logic [3:0] ldo_reg;
  logic [1:0] adc_reg;
  scp_pkg::scp_mode_t mode_reg;
  // clock path state
  logic [3:0] osc_meta, osc_sync, osc_prev;
  logic [3:0] osc_edge; // one-cycle pulse per source rising edge
  logic [`SCP_NUM_EV-1:0] ev_meta, ev_sync, ev_prev, ev_rise;
  logic [1:0] int4_cnt_reg;
  logic [15:0] low_cnt_reg;
  logic int4_edge, low_edge;
  logic [1:0] act_osc_reg; // applied selection, only moves at a boundary
  logic act_pll_reg, act_ext_reg;
  logic [5:0] act_div_reg;
  logic [5:0] div_cnt_reg;
  logic src_edge;
  logic [1:0] want_osc;
  logic want_pll, want_ext;
  logic [5:0] want_div;
  logic [5:0] pwm_cnt_reg;
  logic [5:0] pwm_limit;
  logic tick_reg;

  // bring asynchronous pins into the clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_meta <= 4'h0;
      osc_sync <= 4'h0;
      ev_meta <= '0;
      ev_sync <= '0;
    end else begin
      osc_meta <= osc_pins;
      osc_sync <= osc_meta;
      ev_meta <= event_pins;
      ev_sync <= ev_meta;
    end
  end

  // edge history, read only after the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_prev <= 4'h0;
      ev_prev <= '0;
    end else begin
      osc_prev <= osc_sync;
      ev_prev <= ev_sync;
    end
  end

  // per-bit rising edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_osc_edge
      assign osc_edge[gi] = osc_sync[gi] & ~osc_prev[gi];
    end
    for (gi = 0; gi < `SCP_NUM_EV; gi++) begin : g_ev_edge
      assign ev_rise[gi] = ev_sync[gi] & ~ev_prev[gi];
    end
  endgenerate

  // internal oscillator prescalers; its rate itself is fixed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int4_cnt_reg <= 2'h0;
      low_cnt_reg <= 16'h0000;
    end else if (osc_edge[`SCP_PIN_INT]) begin
      int4_cnt_reg <= int4_cnt_reg + 2'h1;
      if (low_cnt_reg == 16'(LOW_DIV - 1))
        low_cnt_reg <= 16'h0000;
      else
        low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  assign int4_edge = osc_edge[`SCP_PIN_INT] && (int4_cnt_reg == 2'h3);
  assign low_edge = osc_edge[`SCP_PIN_INT] &&
                    (low_cnt_reg == 16'(LOW_DIV - 1));

  // requested source; deep sleep forces the bare crystal, no multiplier
  always_comb begin
    if (mode_reg == scp_pkg::scp_deep) begin
      want_osc = 2'(scp_pkg::osc_select_main);
      want_pll = 1'b0;
      want_ext = 1'b0;
      want_div = 6'h00;
    end else begin
      want_osc = clk_cfg_reg[`SCP_CC_OSC_LSB +: 2];
      want_pll = clk_cfg_reg[`SCP_CC_PLL_BIT];
      want_ext = clk_cfg_reg[`SCP_CC_EXT_BIT];
      want_div = clk_cfg_reg[`SCP_CC_DIV_LSB +: 6];
    end
  end

  // source edge mux over the six sources
  always_comb begin
    src_edge = 1'b0;
    if (act_pll_reg) begin
      src_edge = osc_edge[`SCP_PIN_PLL];
    end else begin
      case (scp_pkg::scp_osc_t'(act_osc_reg))
        scp_pkg::osc_select_main:
          src_edge = act_ext_reg ? osc_edge[`SCP_PIN_EXT] :
                                   osc_edge[`SCP_PIN_MAIN];
        scp_pkg::osc_select_internal: src_edge = osc_edge[`SCP_PIN_INT];
        scp_pkg::osc_select_internal_div4: src_edge = int4_edge;
        scp_pkg::osc_select_internal_low_rate: src_edge = low_edge;
        default: src_edge = 1'b0;
      endcase
    end
  end

  // divider; selection and divisor are taken only at a period boundary
  // so an old period always completes whole before the new one starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
      act_osc_reg <= 2'h0;
      act_pll_reg <= 1'b0;
      act_ext_reg <= 1'b0;
      act_div_reg <= 6'h00;
    end else begin
      tick_reg <= 1'b0;
      if (src_edge) begin
        if (div_cnt_reg >= act_div_reg) begin
          div_cnt_reg <= 6'h00;
          tick_reg <= 1'b1;
          act_osc_reg <= want_osc;
          act_pll_reg <= want_pll;
          act_ext_reg <= want_ext;
          act_div_reg <= want_div;
        end else begin
          div_cnt_reg <= div_cnt_reg + 6'h01;
        end
      end
    end
  end
  assign sys_tick = tick_reg;

  // processor clock only in run mode
  assign cpu_clk_en = tick_reg && (mode_reg == scp_pkg::scp_run);

  // peripheral clock enables per power mode
  always_comb begin
    case (mode_reg)
      scp_pkg::scp_run: periph_clk_en = tick_reg ? run_en_reg : '0;
      scp_pkg::scp_sleep:
        periph_clk_en = !tick_reg ? '0 :
                        (gating_reg ? slp_en_reg : run_en_reg);
      scp_pkg::scp_deep:
        periph_clk_en = !tick_reg ? '0 :
                        (gating_reg ? dslp_en_reg : run_en_reg);
      default: periph_clk_en = '0;
    endcase
  end

  // pwm has its own divider behind the system tick
  assign pwm_limit = 6'((6'h02 << pwm_cfg_reg[3:1]) - 6'h01);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt_reg <= 6'h00;
      pwm_tick <= 1'b0;
    end else begin
      pwm_tick <= 1'b0;
      if (tick_reg) begin
        if (!pwm_cfg_reg[0] || pwm_cnt_reg >= pwm_limit) begin
          pwm_cnt_reg <= 6'h00;
          pwm_tick <= 1'b1;
        end else begin
          pwm_cnt_reg <= pwm_cnt_reg + 6'h01;
        end
      end
    end
  end

  // power mode: software request in, an enabled interrupt or the wake pin out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= scp_pkg::scp_run;
    end else begin
      case (mode_reg)
        scp_pkg::scp_run:
          if (wr && addr == `SCP_OFF_SLEEP && wdata[0])
            mode_reg <= wdata[1] ? scp_pkg::scp_deep : scp_pkg::scp_sleep;
        scp_pkg::scp_sleep, scp_pkg::scp_deep:
          if (sys_irq || ev_rise[`SCP_EV_WAKE])
            mode_reg <= scp_pkg::scp_run;
        default: mode_reg <= scp_pkg::scp_run;
      endcase
    end
  end

  // clock configuration; an in-use oscillator cannot be switched off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_cfg_reg <= `SCP_CLK_CFG_RST;
      pwm_cfg_reg <= 4'h0;
    end else begin
      if (wr && addr == `SCP_OFF_CLK_CFG)
        clk_cfg_reg <= wdata[16:0];
      if (wr && addr == `SCP_OFF_PWM_CFG)
        pwm_cfg_reg <= wdata[3:0];
    end
  end

  // oscillator enables, guarded by what currently clocks the system
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_osc_en <= 1'b1;
      internal_osc_en <= 1'b1;
    end else begin
      main_osc_en <= !clk_cfg_reg[`SCP_CC_MDIS_BIT] ||
                     (act_osc_reg == 2'(scp_pkg::osc_select_main));
      internal_osc_en <= !clk_cfg_reg[`SCP_CC_IDIS_BIT] ||
                         (act_osc_reg != 2'(scp_pkg::osc_select_main));
    end
  end

  // multiplier in use follows the applied selection; reference and crystal code follow the requested word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      multiplier_in_use <= 1'b0;
      pll_ref_sel <= 2'h0;
      crystal_freq_code <= 5'h00;
    end else begin
      multiplier_in_use <= act_pll_reg;
      pll_ref_sel <= clk_cfg_reg[`SCP_CC_OSC_LSB +: 2];
      crystal_freq_code <= clk_cfg_reg[`SCP_CC_XTAL_LSB +: 5];
    end
  end

  // peripheral enable sets and one-cycle peripheral resets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_en_reg <= '0;
      slp_en_reg <= '0;
      dslp_en_reg <= '0;
      gating_reg <= 1'b0;
      periph_rst <= '0;
    end else begin
      periph_rst <= '0;
      if (wr && addr == `SCP_OFF_RUN_EN) run_en_reg <= wdata[NPER-1:0];
      if (wr && addr == `SCP_OFF_SLP_EN) slp_en_reg <= wdata[NPER-1:0];
      if (wr && addr == `SCP_OFF_DSLP_EN) dslp_en_reg <= wdata[NPER-1:0];
      if (wr && addr == `SCP_OFF_GATING) gating_reg <= wdata[0];
      if (wr && addr == `SCP_OFF_PRST) periph_rst <= wdata[NPER-1:0];
    end
  end

  // interrupt status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_irq_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr && addr == `SCP_OFF_IRQ_MASK)
        irq_mask_reg <= wdata[`SCP_NUM_IRQ-1:0];
      if (wr && addr == `SCP_OFF_RAW_IRQ)
        raw_irq_reg <= (raw_irq_reg & ~wdata[`SCP_NUM_IRQ-1:0]) |
                       ev_rise[`SCP_NUM_IRQ-1:0];
      else
        raw_irq_reg <= raw_irq_reg | ev_rise[`SCP_NUM_IRQ-1:0];
    end
  end
  assign sys_irq = |(raw_irq_reg & irq_mask_reg);

  // reset requests and their recorded cause
  logic [`SCP_NUM_RC-1:0] rc_set;
  always_comb begin
    rc_set = '0;
    rc_set[`SCP_RC_BROWNOUT] = ev_rise[`SCP_EV_BROWNOUT] & rst_cfg_reg[0];
    rc_set[`SCP_RC_LDO_LOW] = ev_rise[`SCP_EV_LDO_LOW] & rst_cfg_reg[1];
    rc_set[`SCP_RC_EXT] = ev_rise[`SCP_EV_EXT_RST];
    rc_set[`SCP_RC_SW] = wr && addr == `SCP_OFF_RST_CFG && wdata[2];
    rc_set[`SCP_RC_WDOG] = ev_rise[`SCP_EV_WDOG];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cause_reg <= '0;
      rst_cfg_reg <= `SCP_RST_CFG_RST;
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= |rc_set;
      if (wr && addr == `SCP_OFF_RST_CFG)
        rst_cfg_reg <= wdata[1:0];
      if (wr && addr == `SCP_OFF_RST_CAUSE)
        rst_cause_reg <= (rst_cause_reg & ~wdata[`SCP_NUM_RC-1:0]) |
                         rc_set;
      else
        rst_cause_reg <= rst_cause_reg | rc_set;
    end
  end

  // ldo level and adc rate; out-of-range levels are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ldo_reg <= `SCP_LDO_RST;
      adc_reg <= `SCP_ADC_RST;
    end else begin
      if (wr && addr == `SCP_OFF_LDO && wdata[3:0] <= `SCP_LDO_MAX)
        ldo_reg <= wdata[3:0];
      if (wr && addr == `SCP_OFF_ADC)
        adc_reg <= (wdata[1:0] < ADC_FASTEST) ? ADC_FASTEST : wdata[1:0];
    end
  end
  assign ldo_code = ldo_reg;
  assign adc_rate_select = adc_reg;

  // read mux; data stand only in the cycle after the strobe
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    case (addr)
      `SCP_OFF_CLK_CFG: rd_val = {15'h0000, clk_cfg_reg};
      `SCP_OFF_PWM_CFG: rd_val = {28'h0000000, pwm_cfg_reg};
      `SCP_OFF_SLEEP: rd_val = {30'h00000000, mode_reg};
      `SCP_OFF_GATING: rd_val = {31'h00000000, gating_reg};
      `SCP_OFF_RUN_EN: rd_val = 32'(run_en_reg);
      `SCP_OFF_SLP_EN: rd_val = 32'(slp_en_reg);
      `SCP_OFF_DSLP_EN: rd_val = 32'(dslp_en_reg);
      `SCP_OFF_RAW_IRQ: rd_val = 32'(raw_irq_reg);
      `SCP_OFF_IRQ_MASK: rd_val = 32'(irq_mask_reg);
      `SCP_OFF_MSK_IRQ: rd_val = 32'(raw_irq_reg & irq_mask_reg);
      `SCP_OFF_RST_CAUSE: rd_val = 32'(rst_cause_reg);
      `SCP_OFF_RST_CFG: rd_val = {30'h00000000, rst_cfg_reg};
      `SCP_OFF_LDO: rd_val = {28'h0000000, ldo_reg};
      `SCP_OFF_ADC: rd_val = {30'h00000000, adc_reg};
      `SCP_OFF_CAP_MEM: rd_val = {SRAM_KB, FLASH_KB};
      `SCP_OFF_CAP_PER: rd_val = PERIPH_PRESENT;
      `SCP_OFF_CAP_PIN: rd_val = PIN_PRESENT;
      `SCP_OFF_CLK_STAT:
        rd_val = {20'h00000, act_div_reg, main_osc_en, internal_osc_en,
                  act_ext_reg, act_pll_reg, act_osc_reg};
      default: rd_val = 32'h00000000;
    endcase
  end

  // registered read data, zero when no read was made
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rdata <= 32'h00000000;
    else
      rdata <= rd ? rd_val : 32'h00000000;
  end
endmodule : scp_top

// ==== logic/scp_cfg.svh ====
// constants for the system clock, reset and power control block
// assumes byte offsets on an 8-bit register address, 32-bit data
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// register byte offsets
`define SCP_OFF_CLK_CFG 8'h00
`define SCP_OFF_PWM_CFG 8'h04
`define SCP_OFF_SLEEP 8'h08
`define SCP_OFF_GATING 8'h0c
`define SCP_OFF_RUN_EN 8'h10
`define SCP_OFF_SLP_EN 8'h14
`define SCP_OFF_DSLP_EN 8'h18
`define SCP_OFF_PRST 8'h1c
`define SCP_OFF_RAW_IRQ 8'h20
`define SCP_OFF_IRQ_MASK 8'h24
`define SCP_OFF_MSK_IRQ 8'h28
`define SCP_OFF_RST_CAUSE 8'h2c
`define SCP_OFF_RST_CFG 8'h30
`define SCP_OFF_LDO 8'h34
`define SCP_OFF_ADC 8'h38
`define SCP_OFF_CAP_MEM 8'h3c
`define SCP_OFF_CAP_PER 8'h40
`define SCP_OFF_CAP_PIN 8'h44
`define SCP_OFF_CLK_STAT 8'h48
// clock config field positions
`define SCP_CC_OSC_LSB 0
`define SCP_CC_PLL_BIT 2
`define SCP_CC_EXT_BIT 3
`define SCP_CC_DIV_LSB 4
`define SCP_CC_XTAL_LSB 10
`define SCP_CC_IDIS_BIT 15
`define SCP_CC_MDIS_BIT 16
// reset values, and the top legal ldo code
`define SCP_CLK_CFG_RST 17'h00000
`define SCP_LDO_RST 4'h5
`define SCP_LDO_MAX 4'ha
`define SCP_ADC_RST 2'h0
`define SCP_RST_CFG_RST 2'h3
// oscillator pin indices
`define SCP_PIN_EXT 0
`define SCP_PIN_MAIN 1
`define SCP_PIN_INT 2
`define SCP_PIN_PLL 3
// event input indices
`define SCP_EV_PLL_LOCK 0
`define SCP_EV_CUR_LIM 1
`define SCP_EV_INT_FAIL 2
`define SCP_EV_MAIN_FAIL 3
`define SCP_EV_BROWNOUT 4
`define SCP_EV_LDO_LOW 5
`define SCP_EV_PLL_FAIL 6
`define SCP_EV_EXT_RST 7
`define SCP_EV_WDOG 8
`define SCP_EV_WAKE 9
`define SCP_NUM_EV 10
`define SCP_NUM_IRQ 7
// reset cause bits
`define SCP_RC_BROWNOUT 0
`define SCP_RC_LDO_LOW 1
`define SCP_RC_EXT 2
`define SCP_RC_SW 3
`define SCP_RC_WDOG 4
`define SCP_NUM_RC 5
// slowest crystal code allowed with the multiplier
`define SCP_XTAL_MIN_PLL 5'h04
`endif

// ==== logic/scp_pkg.sv ====
// types shared by the system clock, reset and power control block
// assumes nothing beyond a systemverilog compiler
package scp_pkg;
  // processor power mode
  typedef enum logic [1:0] {
    scp_run,
    scp_sleep,
    scp_deep
  } scp_mode_t;
  // oscillator source selection
  typedef enum logic [1:0] {
    osc_select_main,
    osc_select_internal,
    osc_select_internal_div4,
    osc_select_internal_low_rate
  } scp_osc_t;
endpackage : scp_pkg

// ==== testbench/scp_props.sv ====
// port assertions for scp_top, bound into every instance
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_props #(
  parameter int NPER = 8,
  parameter logic [1:0] ADC_FASTEST = 2'h0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic sys_tick,
  input wire logic cpu_clk_en,
  input wire logic [NPER-1:0] periph_clk_en,
  input wire logic [NPER-1:0] periph_rst,
  input wire logic [1:0] pll_ref_sel,
  input wire logic [4:0] crystal_freq_code,
  input wire logic [3:0] ldo_code,
  input wire logic [1:0] adc_rate_select,
  input wire logic sys_irq,
  input wire logic chip_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // decoded write strobes
  logic wr_ldo, wr_prst, wr_mask, wr_clk, wr_adc, wr_rcfg, ldo_ok;
  logic [1:0] adc_exp; // clamped code, nothing faster than ADC_FASTEST
  assign wr_ldo = wr && addr == `SCP_OFF_LDO;
  assign wr_prst = wr && addr == `SCP_OFF_PRST;
  assign wr_mask = wr && addr == `SCP_OFF_IRQ_MASK;
  assign wr_clk = wr && addr == `SCP_OFF_CLK_CFG;
  assign wr_adc = wr && addr == `SCP_OFF_ADC;
  assign wr_rcfg = wr && addr == `SCP_OFF_RST_CFG;
  assign ldo_ok = wdata[3:0] <= `SCP_LDO_MAX;
  assign adc_exp = (wdata[1:0] < ADC_FASTEST) ? ADC_FASTEST : wdata[1:0];
  chk_cpu_gated: assert property (cpu_clk_en |-> sys_tick)
    else $error("cpu clock enable outside a system tick");
  chk_periph_gated: assert property (|periph_clk_en |-> sys_tick)
    else $error("peripheral enable outside a system tick");
  chk_ldo_range: assert property (ldo_code <= `SCP_LDO_MAX)
    else $error("ldo code above top level");
  chk_ldo_load: assert property (wr_ldo && ldo_ok |=>
    ldo_code == $past(wdata[3:0]))
    else $error("ldo code not loaded");
  chk_ldo_hold: assert property (!(wr_ldo && ldo_ok) |=>
    $stable(ldo_code))
    else $error("ldo code moved without a legal write");
  chk_prst_pulse: assert property (wr_prst |=>
    periph_rst == $past(wdata[NPER-1:0]))
    else $error("peripheral reset pattern wrong");
  chk_prst_cause: assert property (|periph_rst |-> $past(wr_prst))
    else $error("peripheral reset without a write");
  chk_mask_off: assert property (wr_mask && wdata[6:0] == 7'h00 |=>
    !sys_irq)
    else $error("interrupt with every source masked");
  // config register first, then the registered copies one edge later
  chk_ref_sel: assert property (wr_clk |=> ##1
    pll_ref_sel == $past(wdata[1:0], 2) &&
    crystal_freq_code == $past(wdata[14:10], 2))
    else $error("reference or crystal code not taken");
  chk_adc_clamp: assert property (wr_adc |=>
    adc_rate_select == $past(adc_exp))
    else $error("adc rate not clamped");
  chk_sw_reset: assert property (wr_rcfg && wdata[2] |->
    ##[1:4] chip_reset)
    else $error("software reset request ignored");
endmodule : scp_props
bind scp_top scp_props #(.NPER(NPER), .ADC_FASTEST(ADC_FASTEST)) u_props (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
  .sys_tick(sys_tick), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .periph_rst(periph_rst),
  .pll_ref_sel(pll_ref_sel), .crystal_freq_code(crystal_freq_code),
  .ldo_code(ldo_code), .adc_rate_select(adc_rate_select),
  .sys_irq(sys_irq), .chip_reset(chip_reset));

// ==== testbench/test_system_clock_reset_power_control.sv ====
// self-checking bench for scp_top, random traffic from a fixed seed
// assumes 100 mhz clk; oscillator pins are made here as slow squares
`timescale 1ns/10ps
`include "scp_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_system_clock_reset_power_control;
  localparam int NPER = 8;
  localparam logic [1:0] FAST = 2'h1; // adc limit, makes clamping show
  logic clk = 1'b0;
  logic rst_b = 1'b0; // active-low reset
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] osc_pins = 4'h0; // ext, main, internal, multiplier
  logic [9:0] event_pins = 10'h000;
  logic [31:0] rdata, v, m, r;
  logic sys_tick, cpu_clk_en, pwm_tick, multiplier_in_use;
  logic [NPER-1:0] periph_clk_en, periph_rst;
  logic [1:0] pll_ref_sel, adc_rate_select;
  logic [4:0] crystal_freq_code;
  logic main_osc_en, internal_osc_en, sys_irq, chip_reset;
  logic [3:0] ldo_code, ldo_exp;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0; // cycle count for pin patterns
  int n_rst = 0; // chip reset pulses seen
  int n;
  scp_top #(.NPER(NPER), .LOW_DIV(4), .ADC_FASTEST(FAST),
    .FLASH_KB(16'h0100), .SRAM_KB(16'h0040),
    .PERIPH_PRESENT(32'h000000a5), .PIN_PRESENT(32'h00003c3c)) uut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .osc_pins(osc_pins),
    .event_pins(event_pins), .sys_tick(sys_tick),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .periph_rst(periph_rst), .pwm_tick(pwm_tick),
    .multiplier_in_use(multiplier_in_use), .pll_ref_sel(pll_ref_sel),
    .crystal_freq_code(crystal_freq_code), .main_osc_en(main_osc_en),
    .internal_osc_en(internal_osc_en), .ldo_code(ldo_code),
    .adc_rate_select(adc_rate_select), .sys_irq(sys_irq),
    .chip_reset(chip_reset));
  // 10 ns period
  always #5 clk = ~clk;
  // oscillator periods 8, 6, 10 and 4 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc_pins <= {cyc % 4 < 2, cyc % 10 < 5, cyc % 6 < 3, cyc % 8 < 4};
  end
  // reset requests from the block
  always @(posedge clk) if (chip_reset === 1'b1) n_rst++;
  // tick spacing for a clock word; low rate is internal / 4 here
  function automatic int tick_per(input logic [31:0] c);
    int b;
    if (c[2]) b = 4;
    else if (c[1:0] == 2'h0) b = c[3] ? 8 : 6;
    else b = (c[1:0] == 2'h1) ? 10 : 40;
    return b * (c[9:4] + 1);
  endfunction : tick_per
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data is looked at only in the answer cycle
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd_exp
  // cycles to the next tick, bounded so a dead clock cannot hang
  task automatic wait_on(input bit p, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((p ? pwm_tick : sys_tick) !== 1'b1 && c < 9000);
    if (c >= 9000) n_fail++;
  endtask : wait_on
  // first ticks may still run on the old setting
  task automatic period_is(input bit p, input int e);
    repeat (3) wait_on(p, n);
    `CHK(n, e)
  endtask : period_is
  task automatic ev_pulse(input int i);
    @(posedge clk);
    event_pins[i] <= 1'b1;
    repeat (8) @(posedge clk);
    event_pins[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : ev_pulse
  // clock word with a legal crystal code; a multiplier choice pulses
  // its lock flag and clears that interrupt before anything relies on the new clock
  task automatic set_clk(inout logic [31:0] c);
    if (c[2] && c[14:10] < `SCP_XTAL_MIN_PLL)
      c[14:10] = `SCP_XTAL_MIN_PLL;
    wr_reg(`SCP_OFF_CLK_CFG, c);
    @(posedge clk);
    if (c[2]) begin
      ev_pulse(`SCP_EV_PLL_LOCK);
      rd_exp(`SCP_OFF_RAW_IRQ, 32'h1);
      wr_reg(`SCP_OFF_RAW_IRQ, 32'h1);
    end
  endtask : set_clk
  // enter a sleep mode, check gating at a tick, wake by the wake pin
  task automatic sleep_case(input logic [31:0] c, input int per,
      input logic [NPER-1:0] pe);
    wr_reg(`SCP_OFF_SLEEP, c);
    rd_exp(`SCP_OFF_SLEEP, c[1] ? 32'h2 : 32'h1);
    period_is(1'b0, per);
    `CHK({cpu_clk_en, periph_clk_en, multiplier_in_use}, {1'b0, pe, ~c[1]})
    ev_pulse(`SCP_EV_WAKE);
    rd_exp(`SCP_OFF_SLEEP, 32'h0);
  endtask : sleep_case
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // watchdog, about five times the expected run
  initial begin
    #500_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    v = $urandom(60);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_exp(`SCP_OFF_CLK_CFG, 32'h0);
    rd_exp(`SCP_OFF_RST_CFG, 32'h3);
    rd_exp(`SCP_OFF_CAP_MEM, 32'h00400100);
    wr_reg(`SCP_OFF_CAP_PER, 32'hffffffff);
    rd_exp(`SCP_OFF_CAP_PER, 32'h000000a5);
    rd_exp(`SCP_OFF_CAP_PIN, 32'h00003c3c);
    wr_reg(8'h4c, 32'hffffffff);
    rd_exp(8'h4c, 32'h0);
    `CHK({main_osc_en, internal_osc_en, ldo_code}, 6'h35)
    // ldo: top code, one past it, then random
    ldo_exp = 4'h5;
    for (int i = 0; i < 14; i++) begin
      v = (i < 2) ? 10 + i : $urandom % 16;
      wr_reg(`SCP_OFF_LDO, v);
      if (v <= 10) ldo_exp = v[3:0];
      rd_exp(`SCP_OFF_LDO, {28'h0, ldo_exp});
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SCP_OFF_ADC, i);
      rd_exp(`SCP_OFF_ADC, (i < FAST) ? FAST : i);
    end
    r = $urandom;
    wr_reg(`SCP_OFF_RUN_EN, r);
    wait_on(1'b0, n);
    `CHK({cpu_clk_en, periph_clk_en}, {1'b1, r[NPER-1:0]})
    wr_reg(`SCP_OFF_PRST, r);
    #1 `CHK(periph_rst, r[NPER-1:0])
    @(posedge clk);
    #1 `CHK(periph_rst, {NPER{1'b0}})
    // random sources and divisors, last one the largest divisor
    for (int k = 0; k < 7; k++) begin
      v = (k == 6) ? 32'h000013f2 : $urandom & 32'h00007c7f;
      set_clk(v);
      #1 `CHK({pll_ref_sel, crystal_freq_code}, {v[1:0], v[14:10]})
      period_is(1'b0, tick_per(v));
      `CHK(multiplier_in_use, v[2])
      rd_exp(`SCP_OFF_CLK_STAT, {20'h0, v[9:4], 2'h3, v[3:0]});
    end
    wr_reg(`SCP_OFF_CLK_CFG, 32'h0);
    wr_reg(`SCP_OFF_PWM_CFG, 32'h3);
    period_is(1'b1, 24);
    wr_reg(`SCP_OFF_CLK_CFG, 32'h00018000);
    period_is(1'b0, 6);
    `CHK({main_osc_en, internal_osc_en}, 2'b10)
    wr_reg(`SCP_OFF_CLK_CFG, 32'h00018031);
    period_is(1'b0, 40);
    `CHK({main_osc_en, internal_osc_en}, 2'b01)
    v = 32'h00000024;
    set_clk(v);
    m = $urandom;
    wr_reg(`SCP_OFF_SLP_EN, m);
    wr_reg(`SCP_OFF_DSLP_EN, ~m);
    wr_reg(`SCP_OFF_GATING, 32'h1);
    sleep_case(32'h1, 12, m[NPER-1:0]);
    sleep_case(32'h3, 6, ~m[NPER-1:0]);
    wr_reg(`SCP_OFF_GATING, 32'h0);
    sleep_case(32'h1, 12, r[NPER-1:0]);
    // every interrupt source against a random mask
    wr_reg(`SCP_OFF_RST_CFG, 32'h0);
    m = $urandom & 32'h7f;
    wr_reg(`SCP_OFF_IRQ_MASK, m);
    for (int i = 0; i < `SCP_NUM_IRQ; i++) begin
      ev_pulse(i);
      rd_exp(`SCP_OFF_RAW_IRQ, 32'h1 << i);
      rd_exp(`SCP_OFF_MSK_IRQ, m & (32'h1 << i));
      `CHK(sys_irq, m[i])
      wr_reg(`SCP_OFF_RAW_IRQ, 32'h1 << i);
      rd_exp(`SCP_OFF_RAW_IRQ, 32'h0);
    end
    // an enabled interrupt, not the wake pin, ends this sleep
    wr_reg(`SCP_OFF_IRQ_MASK, 32'h1);
    wr_reg(`SCP_OFF_SLEEP, 32'h1);
    rd_exp(`SCP_OFF_SLEEP, 32'h1);
    ev_pulse(`SCP_EV_PLL_LOCK);
    rd_exp(`SCP_OFF_SLEEP, 32'h0);
    wr_reg(`SCP_OFF_RAW_IRQ, 32'h1);
    wr_reg(`SCP_OFF_IRQ_MASK, 32'h0);
    // reset events: brownout, ldo low, external, watchdog
    wr_reg(`SCP_OFF_RST_CFG, 32'h3);
    for (int i = 0; i < 4; i++) begin
      n = n_rst;
      wr_reg(`SCP_OFF_RST_CAUSE, 32'h1f);
      ev_pulse(i < 2 ? 4 + i : 5 + i);
      rd_exp(`SCP_OFF_RST_CAUSE, 32'h1 << (i < 3 ? i : 4));
      `CHK(n_rst, n + 1)
    end
    n = n_rst;
    wr_reg(`SCP_OFF_RST_CAUSE, 32'h1f);
    wr_reg(`SCP_OFF_RST_CFG, 32'h7);
    repeat (6) @(posedge clk);
    rd_exp(`SCP_OFF_RST_CAUSE, 32'h8);
    `CHK(n_rst, n + 1)
    wr_reg(`SCP_OFF_RST_CFG, 32'h0);
    n = n_rst;
    ev_pulse(`SCP_EV_BROWNOUT);
    `CHK(n_rst, n)
    report_and_stop;
  end
endmodule : test_system_clock_reset_power_control
